// [common/bank_map_pkg.sv]
/*
  Constants for the bank address formation and region decoder: widths,
  region bounds, vector table bounds, processor mode codes.
  Assumes nothing of its surroundings; used as bank_map_pkg::name.
*/
package bank_map_pkg;
  localparam int          ADDR_W      = 24;
  localparam int          OFS_W       = 16;
  localparam int          BANK_W      = 8;
  localparam logic [7:0]  BANK_ZERO   = 8'h00;
  localparam logic [15:0] PERIPH_LO   = 16'h0000;
  localparam logic [15:0] PERIPH_HI   = 16'h007F;
  localparam logic [15:0] SRAM_LO     = 16'h0080;
  localparam logic [15:0] SRAM_HI     = 16'h027F;
  localparam logic [15:0] ROM_LO      = 16'hC000;
  localparam logic [15:0] ROM_HI      = 16'hFFFF;
  localparam logic [15:0] VECTOR_LO   = 16'hFFD6;
  localparam logic [15:0] DP_SPAN     = 16'h0100;
  localparam logic [1:0]  MODE_SINGLE = 2'h0;
  localparam logic [1:0]  MODE_EXPAND = 2'h1;
  localparam logic [1:0]  MODE_MICRO  = 2'h2;

  typedef enum logic [2:0] {
    REG_NONE,
    REG_PERIPH,
    REG_SRAM,
    REG_ROM,
    REG_EXT
  } region_t;

  typedef enum logic [1:0] {
    ADDR_FETCH,
    ADDR_DATA_BANK,
    ADDR_DIRECT,
    ADDR_ABSOLUTE
  } addr_kind_t;
endpackage : bank_map_pkg

// [src/bank_address_map_decoder.sv]
/*
  Bank address formation and region decode for the CPU core.
  Assumes the core gives a registered program bank update request, a
  16-bit offset with an access kind, and a processor mode that is settled.
*/
// Summary of operation
// - Space is split into 64 Kbyte banks; bank byte alone selects a bank.
// - Upper byte comes from program bank for fetches, data bank for data-bank accesses, bank zero otherwise.
// - Program counter carry out of a bank increments program bank.
// - Program counter borrow decrements program bank.
// - Peripheral area, static RAM and ROM decode only in bank zero.
// - Direct page is a 256-byte window placed by the direct page base.
// - Direct-page address is base plus instruction offset.
// - Offsets 0 to 7F decode to the peripheral register area.
// - Offsets 80 to 27F decode to the 512-byte static RAM.
// - Offsets C000 to FFFF decode to internal ROM when allowed.
// - Vectors are fetched from FFD6 to FFFF at the ROM top.
// - Bank and 16-bit counter make a 24-bit address over 16 Mbytes.
// - Single-chip mode reaches internal regions only, never external.
// - Microprocessor mode sends the ROM range to the external area.
// - Overlap: reads take internal data; writes go internal and external.
`timescale 1ns/1ps
module bank_address_map_decoder #(
  parameter logic [7:0] PROG_BANK_RESET = 8'h00,
  parameter logic [7:0] DATA_BANK_RESET = 8'h00
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [1:0]  proc_mode,
  input  wire logic        prog_bank_load,
  input  wire logic [7:0]  prog_bank_load_val,
  input  wire logic        data_bank_load,
  input  wire logic [7:0]  data_bank_load_val,
  input  wire logic        dp_base_load,
  input  wire logic [15:0] dp_base_load_val,
  input  wire logic        ip_carry,
  input  wire logic        ip_borrow,
  input  wire logic        acc_valid,
  input  wire logic        acc_write,
  input  wire logic        acc_vector,
  input  wire logic [1:0]  acc_kind,
  input  wire logic [15:0] acc_offset,
  output logic [7:0]       program_bank_reg,
  output logic [7:0]       data_bank_reg,
  output logic [15:0]      direct_page_base_reg,
  output logic [23:0]      phys_addr,
  output logic             sel_periph,
  output logic             sel_sram,
  output logic             sel_rom,
  output logic             ext_req,
  output logic             ext_write,
  output logic             rd_internal,
  output logic             acc_error
);
  logic [7:0]  pbank_r, pbank_nxt;
  logic [7:0]  dbank_r, dbank_nxt;
  logic [15:0] dpbase_r, dpbase_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic        per_r, per_nxt, ram_r, ram_nxt, rom_r, rom_nxt;
  logic        ext_r, ext_nxt, extw_r, extw_nxt, rdi_r, rdi_nxt, err_r, err_nxt;
  logic [23:0] lin;
  logic        bank0, hit_per, hit_ram, hit_rom, internal, ext_allowed;

  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  // Bank registers; a core load beats an overflow adjust in the same cycle
  always_comb begin
    pbank_nxt  = pbank_r;
    dbank_nxt  = dbank_r;
    dpbase_nxt = dpbase_r;
    if (prog_bank_load) begin
      pbank_nxt = prog_bank_load_val;
    end else if (ip_carry && !ip_borrow) begin
      pbank_nxt = pbank_r + 8'h01;
    end else if (ip_borrow && !ip_carry) begin
      pbank_nxt = pbank_r - 8'h01;
    end
    if (data_bank_load) begin
      dbank_nxt = data_bank_load_val;
    end
    if (dp_base_load) begin
      dpbase_nxt = dp_base_load_val;
    end
  end

  // Address formation
  always_comb begin
    lin = {dbank_r, acc_offset};
    unique case (bank_map_pkg::addr_kind_t'(acc_kind))
      bank_map_pkg::ADDR_FETCH:     lin = {pbank_r, acc_offset};
      bank_map_pkg::ADDR_DATA_BANK: lin = {dbank_r, acc_offset};
      // Direct page lives in bank zero; offset byte indexes a 256-byte window
      bank_map_pkg::ADDR_DIRECT:    lin = {bank_map_pkg::BANK_ZERO,
                                           dpbase_r + {8'h00, acc_offset[7:0]}};
      bank_map_pkg::ADDR_ABSOLUTE:  lin = {bank_map_pkg::BANK_ZERO, acc_offset};
    endcase
    // Vectors always come from bank zero
    if (acc_vector) begin
      lin = {bank_map_pkg::BANK_ZERO, acc_offset};
    end
  end

  // Region decode
  always_comb begin
    bank0       = (lin[23:16] == bank_map_pkg::BANK_ZERO);
    hit_per     = bank0 && in_range(lin[15:0], bank_map_pkg::PERIPH_LO,
                                    bank_map_pkg::PERIPH_HI);
    hit_ram     = bank0 && in_range(lin[15:0], bank_map_pkg::SRAM_LO,
                                    bank_map_pkg::SRAM_HI);
    hit_rom     = bank0 && (proc_mode != bank_map_pkg::MODE_MICRO)
                  && in_range(lin[15:0], bank_map_pkg::ROM_LO,
                              bank_map_pkg::ROM_HI);
    internal    = hit_per || hit_ram || hit_rom;
    ext_allowed = (proc_mode == bank_map_pkg::MODE_EXPAND)
                  || (proc_mode == bank_map_pkg::MODE_MICRO);
    addr_nxt = addr_r;
    per_nxt  = 1'b0;
    ram_nxt  = 1'b0;
    rom_nxt  = 1'b0;
    ext_nxt  = 1'b0;
    extw_nxt = 1'b0;
    rdi_nxt  = 1'b0;
    err_nxt  = 1'b0;
    if (acc_valid) begin
      addr_nxt = lin;
      per_nxt  = hit_per;
      ram_nxt  = hit_ram;
      rom_nxt  = hit_rom;
      rdi_nxt  = internal && !acc_write;
      if (ext_allowed) begin
        // Internal overlap: reads stay inside, writes are echoed outside
        ext_nxt  = !internal || acc_write;
        extw_nxt = acc_write;
      end else begin
        err_nxt = !internal;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pbank_r  <= PROG_BANK_RESET;
      dbank_r  <= DATA_BANK_RESET;
      dpbase_r <= 16'h0000;
      addr_r <= 24'h00_0000;
      per_r  <= 1'b0;
      ram_r  <= 1'b0;
      rom_r  <= 1'b0;
      ext_r  <= 1'b0;
      extw_r <= 1'b0;
      rdi_r  <= 1'b0;
      err_r  <= 1'b0;
    end else begin
      pbank_r  <= pbank_nxt;
      dbank_r  <= dbank_nxt;
      dpbase_r <= dpbase_nxt;
      addr_r <= addr_nxt;
      per_r  <= per_nxt;
      ram_r  <= ram_nxt;
      rom_r  <= rom_nxt;
      ext_r  <= ext_nxt;
      extw_r <= extw_nxt;
      rdi_r  <= rdi_nxt;
      err_r  <= err_nxt;
    end
  end

  assign program_bank_reg     = pbank_r;
  assign data_bank_reg        = dbank_r;
  assign direct_page_base_reg = dpbase_r;
  assign phys_addr            = addr_r;
  assign sel_periph           = per_r;
  assign sel_sram             = ram_r;
  assign sel_rom              = rom_r;
  assign ext_req              = ext_r;
  assign ext_write            = extw_r;
  assign rd_internal          = rdi_r;
  assign acc_error            = err_r;

  property p_carry_inc;
    @(posedge clk) disable iff (rst)
      (ip_carry && !ip_borrow && !prog_bank_load) |=> (pbank_r == $past(pbank_r) + 8'h01);
  endproperty
  a_carry_inc: assert property (p_carry_inc) else $error("bank not incremented");

  property p_borrow_dec;
    @(posedge clk) disable iff (rst)
      (ip_borrow && !ip_carry && !prog_bank_load) |=> (pbank_r == $past(pbank_r) - 8'h01);
  endproperty
  a_borrow_dec: assert property (p_borrow_dec) else $error("bank not decremented");

  property p_fetch_bank;
    @(posedge clk) disable iff (rst)
      (acc_valid && !acc_vector && acc_kind == 2'h0)
      |=> (phys_addr == {$past(pbank_r), $past(acc_offset)});
  endproperty
  a_fetch_bank: assert property (p_fetch_bank) else $error("fetch bank wrong");

  property p_internal_bank0;
    @(posedge clk) disable iff (rst)
      (sel_periph || sel_sram || sel_rom) |-> (phys_addr[23:16] == 8'h00);
  endproperty
  a_internal_bank0: assert property (p_internal_bank0) else $error("internal off bank 0");

  property p_periph;
    @(posedge clk) disable iff (rst)
      sel_periph |-> (phys_addr[15:0] <= 16'h007F);
  endproperty
  a_periph: assert property (p_periph) else $error("peripheral range wrong");

  property p_sram;
    @(posedge clk) disable iff (rst)
      sel_sram |-> (phys_addr[15:0] >= 16'h0080 && phys_addr[15:0] <= 16'h027F);
  endproperty
  a_sram: assert property (p_sram) else $error("sram range wrong");

  property p_single_no_ext;
    @(posedge clk) disable iff (rst)
      (proc_mode == 2'h0) ##1 (proc_mode == 2'h0) |-> !ext_req;
  endproperty
  a_single_no_ext: assert property (p_single_no_ext) else $error("external in single");

  property p_micro_no_rom;
    @(posedge clk) disable iff (rst)
      $past(proc_mode) == 2'h2 |-> !sel_rom;
  endproperty
  a_micro_no_rom: assert property (p_micro_no_rom) else $error("rom in micro mode");

  property p_overlap_write;
    @(posedge clk) disable iff (rst)
      (acc_valid && acc_write && proc_mode == 2'h1) |=> (ext_req && ext_write);
  endproperty
  a_overlap_write: assert property (p_overlap_write) else $error("write not echoed");

  property p_data_bank;
    @(posedge clk) disable iff (rst)
      (acc_valid && !acc_vector && acc_kind == bank_map_pkg::ADDR_DATA_BANK)
      |=> (phys_addr == {$past(dbank_r), $past(acc_offset)});
  endproperty
  a_data_bank: assert property (p_data_bank) else $error("data bank wrong");

  // Direct page stays in bank zero and wraps inside the 16-bit offset
  property p_direct_page;
    @(posedge clk) disable iff (rst)
      (acc_valid && !acc_vector && acc_kind == bank_map_pkg::ADDR_DIRECT)
      |=> (phys_addr == {bank_map_pkg::BANK_ZERO,
                         16'($past(dpbase_r) + {8'h00, $past(acc_offset[7:0])})});
  endproperty
  a_direct_page: assert property (p_direct_page) else $error("direct page wrong");

  property p_rom;
    @(posedge clk) disable iff (rst)
      sel_rom |-> (phys_addr[15:0] >= bank_map_pkg::ROM_LO);
  endproperty
  a_rom: assert property (p_rom) else $error("rom range wrong");

  property p_vector;
    @(posedge clk) disable iff (rst)
      (acc_valid && acc_vector)
      |=> (phys_addr == {bank_map_pkg::BANK_ZERO, $past(acc_offset)});
  endproperty
  a_vector: assert property (p_vector) else $error("vector off bank 0");

  // Microprocessor mode: absolute accesses to the ROM range must leave the chip
  property p_micro_rom_ext;
    @(posedge clk) disable iff (rst)
      (acc_valid && proc_mode == bank_map_pkg::MODE_MICRO
       && acc_kind == bank_map_pkg::ADDR_ABSOLUTE && acc_offset >= bank_map_pkg::ROM_LO)
      |=> ext_req;
  endproperty
  a_micro_rom_ext: assert property (p_micro_rom_ext) else $error("rom not external");

  property p_expand_route;
    @(posedge clk) disable iff (rst)
      (acc_valid && !acc_write && proc_mode == bank_map_pkg::MODE_EXPAND)
      |=> (ext_req == !(sel_periph || sel_sram || sel_rom));
  endproperty
  a_expand_route: assert property (p_expand_route) else $error("route wrong");

  property p_single_error;
    @(posedge clk) disable iff (rst)
      (acc_valid && proc_mode == bank_map_pkg::MODE_SINGLE)
      |=> (acc_error == !(sel_periph || sel_sram || sel_rom));
  endproperty
  a_single_error: assert property (p_single_error) else $error("error flag wrong");

  property p_read_internal;
    @(posedge clk) disable iff (rst)
      rd_internal |-> (!ext_req && (sel_periph || sel_sram || sel_rom));
  endproperty
  a_read_internal: assert property (p_read_internal) else $error("read left chip");

  c_rom_hit:    cover property (@(posedge clk) disable iff (rst) sel_rom && !ext_req);
  c_ext_read:   cover property (@(posedge clk) disable iff (rst) ext_req && !ext_write);
  c_bank_wrap:  cover property (@(posedge clk) disable iff (rst)
                                ip_carry && pbank_r == 8'hFF);
  c_overlap_wr: cover property (@(posedge clk) disable iff (rst) ext_write && sel_sram);
  c_single_err: cover property (@(posedge clk) disable iff (rst) acc_error);
endmodule : bank_address_map_decoder

// [verif/bank_address_map_decoder_tb_top.sv]
/*
  Self-checking bench: a random CPU core drives the decoder and a cycle
  model here predicts banks, address and region pulses every clock.
  Assumes results land just after the same edge that takes a request.
*/
`timescale 1ns/1ps
module bank_address_map_decoder_tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [1:0]  proc_mode, acc_kind, m;
  logic        prog_bank_load, data_bank_load, dp_base_load, ip_carry, ip_borrow;
  logic        acc_valid, acc_write, acc_vector, p, s, r, hit, x;
  logic [7:0]  prog_bank_load_val, data_bank_load_val, program_bank_reg, data_bank_reg, bank;
  logic [15:0] dp_base_load_val, acc_offset, direct_page_base_reg, ofs;
  logic [23:0] phys_addr;
  logic        sel_periph, sel_sram, sel_rom, ext_req, ext_write, rd_internal, acc_error;
  logic [7:0]  e_pbank = 8'h00;
  logic [7:0]  e_dbank = 8'h00;
  logic [15:0] e_dpbase = 16'h0000;
  logic [23:0] e_addr = 24'h00_0000;
  logic [6:0]  e_flags = 7'h00;
  wire  [6:0]  got_flags = {sel_periph, sel_sram, sel_rom, ext_req, ext_write,
                            rd_internal, acc_error};
  int          n_fail = 0;
  int          compares = 0;

  always #12.5 clk = ~clk;

  bank_address_map_decoder dut (.clk, .rst, .proc_mode, .prog_bank_load, .prog_bank_load_val,
    .data_bank_load, .data_bank_load_val, .dp_base_load, .dp_base_load_val, .ip_carry,
    .ip_borrow, .acc_valid, .acc_write, .acc_vector, .acc_kind, .acc_offset,
    .program_bank_reg, .data_bank_reg, .direct_page_base_reg, .phys_addr, .sel_periph,
    .sel_sram, .sel_rom, .ext_req, .ext_write, .rd_internal, .acc_error);
  cpu_core_model cpu (.clk, .run(!rst), .proc_mode, .prog_bank_load, .prog_bank_load_val,
    .data_bank_load, .data_bank_load_val, .dp_base_load, .dp_base_load_val, .ip_carry,
    .ip_borrow, .acc_valid, .acc_write, .acc_vector, .acc_kind, .acc_offset);

  task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_flags(input logic [6:0] got, input logic [6:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t flags got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_flags

  task automatic end_of_test;
    if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  // Check what the last edge produced, then predict what the next edge takes
  always @(posedge clk) begin
    #2;
    chk_val(24'(program_bank_reg), 24'(e_pbank));
    chk_val(24'(data_bank_reg), 24'(e_dbank));
    chk_val(24'(direct_page_base_reg), 24'(e_dpbase));
    chk_val(phys_addr, e_addr);
    chk_flags(got_flags, e_flags);
    e_flags = 7'h00;
    if (rst) begin
      {e_pbank, e_dbank, e_dpbase} = '0;
      e_addr = 24'h00_0000;
    end else begin
      if (acc_valid) begin
        m    = proc_mode == 2'h3 ? bank_map_pkg::MODE_SINGLE : proc_mode;
        bank = acc_vector ? 8'h00 :
               acc_kind == 2'h0 ? e_pbank : acc_kind == 2'h1 ? e_dbank : 8'h00;
        ofs  = acc_kind == 2'h2 ? e_dpbase + {8'h00, acc_offset[7:0]} : acc_offset;
        p    = bank == 8'h00 && ofs <= 16'h007F;
        s    = bank == 8'h00 && ofs >= 16'h0080 && ofs <= 16'h027F;
        r    = bank == 8'h00 && ofs >= 16'hC000 && m != bank_map_pkg::MODE_MICRO;
        hit  = p | s | r;
        x    = m != bank_map_pkg::MODE_SINGLE && (!hit || acc_write);
        e_addr  = {bank, ofs};
        e_flags = {p, s, r, x, x && acc_write, hit && !acc_write, !hit && !x};
      end
      if (prog_bank_load) e_pbank = prog_bank_load_val;
      else if (ip_carry && !ip_borrow) e_pbank = e_pbank + 8'h01;
      else if (ip_borrow && !ip_carry) e_pbank = e_pbank - 8'h01;
      if (data_bank_load) e_dbank = data_bank_load_val;
      if (dp_base_load) e_dpbase = dp_base_load_val;
    end
  end

  initial begin
    void'($urandom(23));
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    repeat (3000) @(posedge clk);
    #1 rst = 1'b1;
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    repeat (1000) @(posedge clk);
    end_of_test();
  end
endmodule : bank_address_map_decoder_tb_top

// [verif/cpu_core_model.sv]
/*
  Stand-in for the CPU core: each cycle it may load a bank or the direct
  page base, report a counter carry or borrow, or issue one access.
  Assumes clk from the bench; run low keeps every request idle.
*/
`timescale 1ns/1ps
module cpu_core_model (
  input  wire logic   clk,
  input  wire logic   run,
  output logic [1:0]  proc_mode,
  output logic        prog_bank_load,
  output logic [7:0]  prog_bank_load_val,
  output logic        data_bank_load,
  output logic [7:0]  data_bank_load_val,
  output logic        dp_base_load,
  output logic [15:0] dp_base_load_val,
  output logic        ip_carry,
  output logic        ip_borrow,
  output logic        acc_valid,
  output logic        acc_write,
  output logic        acc_vector,
  output logic [1:0]  acc_kind,
  output logic [15:0] acc_offset
);
  // Region edges come up far more often than pure chance would give
  logic [15:0] edge_ofs [9] = '{16'h0000, 16'h007F, 16'h0080, 16'h027F, 16'h0280,
                                16'hBFFF, 16'hC000, 16'hFFD5, 16'hFFFF};
  int unsigned op;
  initial begin
    {proc_mode, prog_bank_load, prog_bank_load_val, data_bank_load} = '0;
    {data_bank_load_val, dp_base_load, dp_base_load_val} = '0;
    {ip_carry, ip_borrow, acc_valid, acc_write} = '0;
    {acc_vector, acc_kind, acc_offset} = '0;
  end
  always @(posedge clk) begin
    #1;
    op = run ? $urandom_range(9) : 10;
    if ($urandom_range(31) == 0) proc_mode = 2'($urandom);
    prog_bank_load     = (op == 4);
    prog_bank_load_val = $urandom_range(2) == 0 ? 8'($urandom) : 8'h00;
    data_bank_load     = (op == 7);
    data_bank_load_val = 8'($urandom);
    dp_base_load       = (op == 8);
    dp_base_load_val   = $urandom_range(1) == 1 ? 16'($urandom) : 16'($urandom_range(767));
    ip_carry           = op == 5 || op == 9 || (op == 4 && $urandom_range(1) == 1);
    ip_borrow          = op == 6 || op == 9;
    acc_valid    = op < 4;
    acc_write    = acc_valid && $urandom_range(1) == 1;
    acc_vector   = acc_valid && !acc_write && $urandom_range(7) == 0;
    acc_kind     = acc_vector ? 2'h0 : 2'($urandom);
    acc_offset   = $urandom_range(1) == 1 ? edge_ofs[$urandom_range(8)] : 16'($urandom);
    if (acc_vector) acc_offset = 16'hFFD6 + 16'($urandom_range(41));
  end
endmodule : cpu_core_model
